// ---- bscd_board_model.sv ----
/*
 board side: cold reset source and strap drivers with pull resistors.
 assumes the bench asks for reset and strap levels on its own clock.
*/
`default_nettype none

module bscd_board_model (
   // clock
   input  wire logic        clk_i,
   // reset source and strap driver control
   input  wire logic        rst_req_i,
   input  wire logic        drive_i,
   input  wire logic [15:0] val_i,
   input  wire logic [15:0] pull_i,
   // to the device
   output wire logic        reset_n_o,
   output wire logic [15:0] pins_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic rst_n_r = 1'b0;

   always @(posedge clk_i or posedge rst_req_i) begin
      if (rst_req_i) rst_n_r <= 1'b0;
      else rst_n_r <= 1'b1;
   end
   assign reset_n_o = rst_n_r;

   // reserved bits low, released pins go to pull level
   assign pins_o = drive_i ? {2'h0, val_i[13:0]} : pull_i;
endmodule

`default_nettype wire

// ---- bscd_decoder.sv ----
/*
 boot strap configuration decoder: captures the strap word after the
 cold power-on reset is released, decodes it and then hands the pins
 back for general-purpose use.
 assumes reset_n_i is the cold power-on reset, already deasserted
 synchronously to clk_i, and that strap pins are steady around release.
*/
// Behaviour
// - sample all sixteen strap pins at cold reset release, use as configuration
// - after capture release strap pins for general-purpose use
// - always start internal rom loader first, whatever device is selected
// - bits 13:10 give backup device, used when primary boot fails
// - bits 2:0 pick reference clock, codes 110 and 111 reserved
// - bits 6:3 pick primary boot device, 0000 reserved
// - card boot uses port 0 at 8 bits; bit 7 filesystem or raw
// - spi nor: bit 7 chip select, bit 8 clock mode 0 or 3
`default_nettype none

module bscd_decoder (
   // clock and cold reset
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   // strap pins
   input  wire logic [15:0] boot_strap_word_i,
   // boot loader handshake
   input  wire logic        primary_fail_i,
   // capture status and pin handover
   output var  logic        strap_valid_o,
   output var  logic        pins_released_o,
   output var  logic        rom_loader_start_o,
   output var  logic [15:0] boot_strap_word_o,
   // decoded configuration
   output var  logic [2:0]  refclk_sel_o,
   output var  logic [3:0]  primary_dev_o,
   output var  logic [3:0]  backup_dev_o,
   output var  logic [3:0]  active_dev_o,
   output var  logic        use_backup_o,
   output var  logic        config_invalid_o,
   output var  logic        reserved_nonzero_o,
   // card port options
   output var  logic        card_port_sel_o,
   output var  logic        card_port_8bit_o,
   output var  logic        card_port_raw_o,
   output var  logic        card_port_bad_strap_o,
   // spi nor options
   output var  logic        spi_cs1_o,
   output var  logic        spi_mode3_o
);

   // ==========================================================
   // synchroniser for the strap pins
   logic [15:0] pins_sync;

   bscd_sync2 #(
      .W (bscd_pkg::STRAP_W)
   ) u_sync (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .d_i       (boot_strap_word_i),
      .q_o       (pins_sync)
   );

   // ==========================================================
   // capture sequencer
   bscd_pkg::bscd_state_t state_r;
   bscd_pkg::bscd_state_t state_nxt;
   logic [1:0]            cnt_r;
   logic [1:0]            cnt_nxt;
   logic [15:0]           word_r;
   logic [15:0]           word_nxt;
   logic                  cap;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      word_nxt  = word_r;
      cap       = 1'b0;
      case (state_r)
         bscd_pkg::BSCD_ST_WAIT: begin
            state_nxt = bscd_pkg::BSCD_ST_SYNC;
            cnt_nxt   = 2'h0;
         end
         // wait until synchroniser carries post-release pin levels
         bscd_pkg::BSCD_ST_SYNC: begin
            cnt_nxt = cnt_r + 2'h1;
            if (cnt_r == 2'(bscd_pkg::SYNC_STAGES - 1)) begin
               word_nxt  = pins_sync;
               cap       = 1'b1;
               state_nxt = bscd_pkg::BSCD_ST_HOLD;
            end
         end
         bscd_pkg::BSCD_ST_HOLD: begin
            state_nxt = bscd_pkg::BSCD_ST_HOLD;
         end
         default: begin
            state_nxt = bscd_pkg::BSCD_ST_WAIT;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_r <= bscd_pkg::BSCD_ST_WAIT;
         cnt_r   <= 2'h0;
         word_r  <= bscd_pkg::STRAP_RST;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         word_r  <= word_nxt;
      end
   end

   // ==========================================================
   // field decode of the captured word
   logic [2:0] ref_f;
   logic [3:0] pri_f;
   logic [3:0] bak_f;
   logic       ref_bad;
   logic       pri_bad;

   always_comb begin
      ref_f = word_nxt[bscd_pkg::REFCLK_MSB:bscd_pkg::REFCLK_LSB];
      pri_f = word_nxt[bscd_pkg::PRIMARY_MSB:bscd_pkg::PRIMARY_LSB];
      bak_f = word_nxt[bscd_pkg::BACKUP_MSB:bscd_pkg::BACKUP_LSB];
      ref_bad = (ref_f == bscd_pkg::BSCD_REF_RSV6) || (ref_f == bscd_pkg::BSCD_REF_RSV7);
      pri_bad = (pri_f == bscd_pkg::BSCD_DEV_RSVD);
   end

   // ==========================================================
   // registered outputs, loaded once at capture; active_dev_o and use_backup_o again at fallback
   logic        done_r;
   logic        done_nxt;
   logic        fail_r;
   logic        fail_nxt;
   logic        valid_nxt;
   logic        released_nxt;
   logic        rom_start_nxt;
   logic [15:0] word_out_nxt;
   logic [2:0]  refclk_nxt;
   logic [3:0]  primary_nxt;
   logic [3:0]  backup_nxt;
   logic [3:0]  active_nxt;
   logic        use_backup_nxt;
   logic        invalid_nxt;
   logic        reserved_nxt;
   logic        card_sel_nxt;
   logic        card_8bit_nxt;
   logic        card_raw_nxt;
   logic        card_bad_nxt;
   logic        spi_cs1_nxt;
   logic        spi_mode3_nxt;

   always_comb begin
      done_nxt       = done_r | cap;
      // fallback latches; cleared only by cold reset
      fail_nxt       = fail_r | (done_r & primary_fail_i);
      valid_nxt      = strap_valid_o;
      released_nxt   = pins_released_o;
      rom_start_nxt  = rom_loader_start_o;
      word_out_nxt   = boot_strap_word_o;
      refclk_nxt     = refclk_sel_o;
      primary_nxt    = primary_dev_o;
      backup_nxt     = backup_dev_o;
      active_nxt     = active_dev_o;
      use_backup_nxt = use_backup_o;
      invalid_nxt    = config_invalid_o;
      reserved_nxt   = reserved_nonzero_o;
      card_sel_nxt   = card_port_sel_o;
      card_8bit_nxt  = card_port_8bit_o;
      card_raw_nxt   = card_port_raw_o;
      card_bad_nxt   = card_port_bad_strap_o;
      spi_cs1_nxt    = spi_cs1_o;
      spi_mode3_nxt  = spi_mode3_o;
      if (cap) begin
         valid_nxt     = 1'b1;
         released_nxt  = 1'b1;
         rom_start_nxt = 1'b1;
         word_out_nxt  = word_nxt;
         refclk_nxt    = ref_f;
         primary_nxt   = pri_f;
         backup_nxt    = bak_f;
         active_nxt    = pri_f;
         invalid_nxt   = ref_bad | pri_bad;
         reserved_nxt  = |word_nxt[bscd_pkg::RSVD_MSB:bscd_pkg::RSVD_LSB];
         // card port 0, 8 bit, fs or raw
         card_sel_nxt  = 1'b0;
         card_8bit_nxt = (pri_f == bscd_pkg::BSCD_DEV_CARD);
         card_raw_nxt  = (pri_f == bscd_pkg::BSCD_DEV_CARD) &
                         word_nxt[bscd_pkg::OPT_SEL_BIT];
         card_bad_nxt  = (pri_f == bscd_pkg::BSCD_DEV_CARD) &
                         word_nxt[bscd_pkg::CARD_WIDTH_BIT];
         // spi nor chip select and mode
         spi_cs1_nxt   = (pri_f == bscd_pkg::BSCD_DEV_SPI) &
                         word_nxt[bscd_pkg::OPT_SEL_BIT];
         spi_mode3_nxt = (pri_f == bscd_pkg::BSCD_DEV_SPI) &
                         word_nxt[bscd_pkg::SPI_MODE_BIT];
      end else if (fail_nxt && !fail_r) begin
         use_backup_nxt = 1'b1;
         active_nxt     = backup_dev_o;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         done_r                <= 1'b0;
         fail_r                <= 1'b0;
         strap_valid_o         <= 1'b0;
         pins_released_o       <= 1'b0;
         rom_loader_start_o    <= 1'b0;
         boot_strap_word_o     <= bscd_pkg::STRAP_RST;
         refclk_sel_o          <= 3'h0;
         primary_dev_o         <= 4'h0;
         backup_dev_o          <= 4'h0;
         active_dev_o          <= 4'h0;
         use_backup_o          <= 1'b0;
         config_invalid_o      <= 1'b0;
         reserved_nonzero_o    <= 1'b0;
         card_port_sel_o       <= 1'b0;
         card_port_8bit_o      <= 1'b0;
         card_port_raw_o       <= 1'b0;
         card_port_bad_strap_o <= 1'b0;
         spi_cs1_o             <= 1'b0;
         spi_mode3_o           <= 1'b0;
      end else begin
         done_r                <= done_nxt;
         fail_r                <= fail_nxt;
         strap_valid_o         <= valid_nxt;
         pins_released_o       <= released_nxt;
         rom_loader_start_o    <= rom_start_nxt;
         boot_strap_word_o     <= word_out_nxt;
         refclk_sel_o          <= refclk_nxt;
         primary_dev_o         <= primary_nxt;
         backup_dev_o          <= backup_nxt;
         active_dev_o          <= active_nxt;
         use_backup_o          <= use_backup_nxt;
         config_invalid_o      <= invalid_nxt;
         reserved_nonzero_o    <= reserved_nxt;
         card_port_sel_o       <= card_sel_nxt;
         card_port_8bit_o      <= card_8bit_nxt;
         card_port_raw_o       <= card_raw_nxt;
         card_port_bad_strap_o <= card_bad_nxt;
         spi_cs1_o             <= spi_cs1_nxt;
         spi_mode3_o           <= spi_mode3_nxt;
      end
   end

endmodule

`default_nettype wire

// ---- bscd_decoder_sva.sv ----
/*
 checker: timing and decode properties on the strap decoder ports.
 assumes one clock domain and a bind onto bscd_decoder.
*/
`default_nettype none

module bscd_decoder_sva (
   // clock, cold reset and boot loader handshake
   input wire logic        clk_i,
   input wire logic        reset_n_i,
   input wire logic        primary_fail_i,
   // capture status
   input wire logic        strap_valid_o,
   input wire logic        pins_released_o,
   input wire logic        rom_loader_start_o,
   input wire logic [15:0] boot_strap_word_o,
   // decoded fields
   input wire logic [2:0]  refclk_sel_o,
   input wire logic [3:0]  primary_dev_o,
   input wire logic [3:0]  backup_dev_o,
   input wire logic [3:0]  active_dev_o,
   input wire logic        use_backup_o,
   input wire logic        config_invalid_o,
   input wire logic        reserved_nonzero_o,
   // device options
   input wire logic        card_port_sel_o,
   input wire logic        card_port_8bit_o,
   input wire logic        card_port_raw_o,
   input wire logic        card_port_bad_strap_o,
   input wire logic        spi_cs1_o,
   input wire logic        spi_mode3_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   // ==========================================================
   // capture
   sequence s_capture_wait;
      !strap_valid_o ##1 !strap_valid_o;
   endsequence

   a_capture_after_release: assert property (
      $rose(reset_n_i) |-> s_capture_wait ##[2:4] strap_valid_o) else $error("capture timing");
   a_word_held: assert property (
      strap_valid_o |=> strap_valid_o && $stable(boot_strap_word_o)) else $error("word moved");
   a_pins_handover: assert property (
      pins_released_o == strap_valid_o) else $error("pins handover");
   a_rom_first: assert property (
      $rose(strap_valid_o) |-> rom_loader_start_o && active_dev_o == primary_dev_o)
      else $error("rom loader start");
   a_fields_decode: assert property (
      strap_valid_o |-> refclk_sel_o == boot_strap_word_o[2:0]
         && primary_dev_o == boot_strap_word_o[6:3] && backup_dev_o == boot_strap_word_o[13:10])
      else $error("field decode");
   a_invalid_flag: assert property (
      strap_valid_o |-> config_invalid_o == (refclk_sel_o[2:1] == 2'h3 || primary_dev_o == 4'h0))
      else $error("invalid flag");
   a_card_options: assert property (
      strap_valid_o |-> !card_port_sel_o && card_port_8bit_o == (primary_dev_o == 4'h8)
         && card_port_raw_o == (card_port_8bit_o && boot_strap_word_o[7])
         && card_port_bad_strap_o == (card_port_8bit_o && boot_strap_word_o[9]))
      else $error("card options");
   a_spi_options: assert property (
      strap_valid_o |-> spi_cs1_o == (primary_dev_o == 4'h3 && boot_strap_word_o[7])
         && spi_mode3_o == (primary_dev_o == 4'h3 && boot_strap_word_o[8]))
      else $error("spi options");
   a_backup_switch: assert property (
      strap_valid_o && primary_fail_i |=> use_backup_o && active_dev_o == backup_dev_o)
      else $error("no fallback");
   a_primary_used: assert property (
      strap_valid_o && !use_backup_o |-> active_dev_o == primary_dev_o) else $error("active dev");
   a_backup_sticky: assert property (
      use_backup_o |=> use_backup_o) else $error("fallback dropped");
   a_reserved_flag: assert property (
      strap_valid_o |-> reserved_nonzero_o == (boot_strap_word_o[15:14] != 2'h0))
      else $error("reserved flag");
endmodule

bind bscd_decoder bscd_decoder_sva chk_u (.*);

`default_nettype wire

// ---- bscd_pkg.sv ----
/*
 boot strap configuration decoder: shared constants and types.
 assumes a single 200 mhz clock domain and the strap word layout below.
*/
`default_nettype none

package bscd_pkg;

   // ==========================================================
   // strap word layout
   localparam int STRAP_W        = 16;
   localparam int RSVD_MSB       = 15;
   localparam int RSVD_LSB       = 14;
   localparam int BACKUP_MSB     = 13;
   localparam int BACKUP_LSB     = 10;
   localparam int CARD_WIDTH_BIT = 9;
   localparam int SPI_MODE_BIT   = 8;
   localparam int OPT_SEL_BIT    = 7;
   localparam int PRIMARY_MSB    = 6;
   localparam int PRIMARY_LSB    = 3;
   localparam int REFCLK_MSB     = 2;
   localparam int REFCLK_LSB     = 0;

   // ==========================================================
   // reset values
   localparam logic [15:0] STRAP_RST = 16'h0000;

   // ==========================================================
   // timing: pins pass a two-stage synchroniser, then settle
   localparam int SYNC_STAGES = 2;

   // ==========================================================
   // reference clock codes
   typedef enum logic [2:0] {
      BSCD_REF_19M2 = 3'h0,
      BSCD_REF_20M  = 3'h1,
      BSCD_REF_24M  = 3'h2,
      BSCD_REF_25M  = 3'h3,
      BSCD_REF_26M  = 3'h4,
      BSCD_REF_27M  = 3'h5,
      BSCD_REF_RSV6 = 3'h6,
      BSCD_REF_RSV7 = 3'h7
   } bscd_refclk_t;

   // ==========================================================
   // boot device codes, shared by primary and backup fields
   typedef enum logic [3:0] {
      BSCD_DEV_RSVD  = 4'h0,
      BSCD_DEV_OSPI  = 4'h1,
      BSCD_DEV_QSPI  = 4'h2,
      BSCD_DEV_SPI   = 4'h3,
      BSCD_DEV_RGMII = 4'h4,
      BSCD_DEV_RMII  = 4'h5,
      BSCD_DEV_I2C   = 4'h6,
      BSCD_DEV_UART  = 4'h7,
      BSCD_DEV_CARD  = 4'h8,
      BSCD_DEV_EMMC  = 4'h9,
      BSCD_DEV_USB   = 4'ha,
      BSCD_DEV_NAND  = 4'hb,
      BSCD_DEV_NOR   = 4'hc,
      BSCD_DEV_PCIE  = 4'hd,
      BSCD_DEV_XSPI  = 4'he,
      BSCD_DEV_NOBT  = 4'hf
   } bscd_dev_t;

   // ==========================================================
   // capture sequencer
   typedef enum logic [1:0] {
      BSCD_ST_WAIT = 2'b00,
      BSCD_ST_SYNC = 2'b01,
      BSCD_ST_HOLD = 2'b10
   } bscd_state_t;

endpackage

`default_nettype wire

// ---- bscd_sync2.sv ----
/*
 two flip-flop level synchroniser, parameterised width.
 assumes the input is quasi-static, as strap pins are.
*/
`default_nettype none

module bscd_sync2 #(
   parameter int W = 16
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         reset_n_i,
   // data
   input  wire logic [W-1:0] d_i,
   output var  logic [W-1:0] q_o
);

   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_nxt;

   always_comb begin
      meta_nxt = d_i;
      q_nxt    = meta_r;
   end

   // first stage is only read by the second
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_r <= '0;
         q_o    <= '0;
      end else begin
         meta_r <= meta_nxt;
         q_o    <= q_nxt;
      end
   end

endmodule

`default_nettype wire

// ---- tb.sv ----
/*
 bench for the strap decoder: table of strap words, then fallback and reset.
 assumes the board model as reset source and strap driver.
*/
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [15:0] word;
      logic [4:0]  flags;
   } bscd_row_t;

   logic        clk_i = 1'b0;
   logic        rst_req = 1'b1, drive = 1'b1, fail = 1'b0;
   logic [15:0] val = 16'h0000, pull = 16'h0000, pins, word_o;
   logic        reset_n, valid, rom_start, use_bk, inv, card8, raw, cs1, m3;
   logic        rel, csel, rsv, bad;
   logic [2:0]  refclk;
   logic [3:0]  prim, bk, act;
   int          mismatches = 0, n_checks = 0, cycles = 0;
   // flags: invalid, card 8 bit, raw, cs1, mode 3
   bscd_row_t   rows [19] = '{'{16'h3c00, 5'h10}, '{16'h3909, 5'h00}, '{16'h3492, 5'h00},
      '{16'h319b, 5'h03}, '{16'h2c24, 5'h00}, '{16'h292d, 5'h00}, '{16'h24b6, 5'h10},
      '{16'h21bf, 5'h10}, '{16'h1c40, 5'h08}, '{16'h1949, 5'h00}, '{16'h14d2, 5'h00},
      '{16'h11db, 5'h00}, '{16'h0c64, 5'h00}, '{16'h096d, 5'h00}, '{16'h04f6, 5'h10},
      '{16'h01ff, 5'h10}, '{16'h009b, 5'h02}, '{16'h011b, 5'h01}, '{16'h02c0, 5'h0c}};

   bscd_board_model board_u (.clk_i(clk_i), .rst_req_i(rst_req), .drive_i(drive),
      .val_i(val), .pull_i(pull), .reset_n_o(reset_n), .pins_o(pins));
   bscd_decoder dut_u (.clk_i(clk_i), .reset_n_i(reset_n), .boot_strap_word_i(pins),
      .primary_fail_i(fail), .strap_valid_o(valid), .pins_released_o(rel),
      .rom_loader_start_o(rom_start), .boot_strap_word_o(word_o), .refclk_sel_o(refclk),
      .primary_dev_o(prim), .backup_dev_o(bk), .active_dev_o(act), .use_backup_o(use_bk),
      .config_invalid_o(inv), .reserved_nonzero_o(rsv), .card_port_sel_o(csel),
      .card_port_8bit_o(card8), .card_port_raw_o(raw), .card_port_bad_strap_o(bad),
      .spi_cs1_o(cs1), .spi_mode3_o(m3));

   always #2.5 clk_i = ~clk_i;

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic complete_run();
      if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // early fail pulse lands between release and capture, where it must be ignored
   task automatic boot(input logic [15:0] w, input logic early_fail);
      int k;
      @(posedge clk_i);
      rst_req <= 1'b1;
      // a word with reserved bits set comes from misstrapped pulls, drivers off
      drive <= (w[15:14] == 2'h0);
      val <= w;
      pull <= (w[15:14] == 2'h0) ? ~w : w;
      repeat (2) @(posedge clk_i);
      rst_req <= 1'b0;
      fail <= early_fail;
      repeat (3) @(posedge clk_i);
      fail <= 1'b0;
      k = 0;
      while (valid !== 1'b1 && k < 12) begin
         @(posedge clk_i);
         k++;
      end
      #1;
      check("strap_valid_o", 16'h0001, 16'(valid));
   endtask

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         complete_run();
      end
   end

   initial begin
      repeat (6) @(posedge clk_i);
      foreach (rows[i]) begin
         boot(rows[i].word, 1'b0);
         check("boot_strap_word_o", rows[i].word, word_o);
         check("refclk_sel_o", 16'(rows[i].word[2:0]), 16'(refclk));
         check("primary_dev_o", 16'(rows[i].word[6:3]), 16'(prim));
         check("backup_dev_o", 16'(rows[i].word[13:10]), 16'(bk));
         check("flags", 16'(rows[i].flags), 16'({inv, card8, raw, cs1, m3}));
         check("rom_loader_start_o", 16'h0001, 16'(rom_start));
         check("pins_released_o", 16'h0001, 16'(rel));
         check("card_port_sel_o", 16'h0000, 16'(csel));
         check("card_port_bad_strap_o",
            16'((rows[i].word[6:3] == 4'h8) & rows[i].word[9]), 16'(bad));
         check("reserved_nonzero_o", 16'h0000, 16'(rsv));
         @(posedge clk_i);
         drive <= 1'b0;
         repeat (4) @(posedge clk_i);
         #1;
         check("held word", rows[i].word, word_o);
      end
      boot(16'hc01b, 1'b0);
      check("reserved_nonzero_o set", 16'h0001, 16'(rsv));
      check("reserved word", 16'hc01b, word_o);
      boot(16'h1c40, 1'b1);
      check("use_backup_o early", 16'h0000, 16'(use_bk));
      check("active_dev_o", 16'h0008, 16'(act));
      @(posedge clk_i);
      fail <= 1'b1;
      @(posedge clk_i);
      fail <= 1'b0;
      @(posedge clk_i);
      #1;
      check("use_backup_o", 16'h0001, 16'(use_bk));
      check("active_dev_o backup", 16'h0007, 16'(act));
      @(posedge clk_i);
      rst_req <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      check("reset word", 16'h0000, word_o);
      check("reset valid", 16'h0000, 16'({valid, use_bk, rel}));
      complete_run();
   end
endmodule

`default_nettype wire
